/* design/cps_check_calc.sv */
// Running check value over accepted register data words, with address folded in.
// Assumes it sees each data word for exactly one cycle of clk_sys.
`timescale 1ns/1ps
module cps_check_calc (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic update,
  input wire logic [4:0] addr,
  input wire logic [31:0] data,
  output logic [31:0] value
);
  import cps_pkg::*;
  logic [31:0] next_value;

  function automatic logic [31:0] cps_crc_step(input logic [31:0] crc, input logic [36:0] din);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 37; i++) begin
      c = (c[0] ^ din[i]) ? ((c >> 1) ^ CPS_CHECK_POLY) : (c >> 1);
    end
    return c;
  endfunction : cps_crc_step

  always_comb begin
    next_value = value;
    if (clear) begin
      next_value = CPS_CHECK_SEED;
    end else if (update) begin
      next_value = cps_crc_step(value, {addr, data});
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      value <= CPS_CHECK_SEED;
    end else begin
      value <= next_value;
    end
  end
endmodule : cps_check_calc

/* design/cps_pkg.sv */
// Constants shared by the configuration packet sequencer.
// Assumes a single 100 MHz system clock domain.
package cps_pkg;
  localparam logic [31:0] CPS_SYNC_WORD = 32'haa995566;
  localparam logic [31:0] CPS_NOOP_WORD = 32'h20000000;
  localparam logic [2:0] CPS_HDR_SINGLE = 3'h1;
  localparam logic [2:0] CPS_HDR_LONG = 3'h2;
  localparam int CPS_HDR_TYPE_HI = 31;
  localparam int CPS_HDR_TYPE_LO = 29;
  localparam int CPS_OP_HI = 28;
  localparam int CPS_OP_LO = 27;
  localparam int CPS_ADDR_HI = 17;
  localparam int CPS_ADDR_LO = 13;
  localparam int CPS_WC1_HI = 10;
  localparam int CPS_WC2_HI = 26;
  localparam int CPS_CMD_HI = 4;
  localparam logic [1:0] CPS_OP_NOP = 2'h0;
  localparam logic [1:0] CPS_OP_WRITE = 2'h2;
  localparam logic [4:0] CPS_REG_CHECK = 5'h00;
  localparam logic [4:0] CPS_REG_FRAME_ADDR = 5'h01;
  localparam logic [4:0] CPS_REG_FRAME_DATA = 5'h02;
  localparam logic [4:0] CPS_REG_COMMAND = 5'h04;
  localparam logic [4:0] CPS_REG_CTRL0 = 5'h05;
  localparam logic [4:0] CPS_REG_MASK = 5'h06;
  localparam logic [4:0] CPS_REG_CTRL1 = 5'h18;
  localparam logic [4:0] CPS_CMD_WRITE_FRAMES = 5'h01;
  localparam logic [4:0] CPS_CMD_RELEASE_HOLD = 5'h03;
  localparam logic [4:0] CPS_CMD_START = 5'h05;
  localparam logic [4:0] CPS_CMD_RESET_CHECK = 5'h07;
  localparam logic [4:0] CPS_CMD_RESTORE = 5'h0a;
  localparam logic [4:0] CPS_CMD_DROP_ALIGN = 5'h0d;
  localparam logic [31:0] CPS_CHECK_SEED = 32'h00000000;
  localparam logic [31:0] CPS_CHECK_POLY = 32'h1edc6f41;
  localparam logic [26:0] CPS_WC_ZERO = 27'h0000000;
  localparam logic [26:0] CPS_WC_ONE = 27'h0000001;
  typedef enum logic [1:0] {CPS_ST_HUNT, CPS_ST_HEADER, CPS_ST_DATA} cps_state_e;
endpackage : cps_pkg

/* design/cps_sequencer.sv */
// Configuration packet sequencer: aligns, decodes packets, runs commands.
// Assumes cfg_word_valid comes from logic on clk_sys; one word per valid cycle.
// Operation
// (RULE1) Discard all words until the sync word is seen.
// (RULE2) Single-register header type is 001; opcode selects no-op, read or write.
// (RULE3) Long-block header reuses previous address; count in bits 26 to 0.
// (RULE4) The no-operation word changes nothing and starts nothing.
// (RULE5) Headers 3000A001 and 30030001 write control words zero and one.
// (RULE6) A 32-bit mask loaded by 3000C001 governs control word writes.
// (RULE7) Control writes change only bits where the mask is one.
// (RULE8) Header 30002001 loads the frame address for later frame data.
// (RULE9) Header 30008001 writes the command; low five bits are acted on.
// (RULE10) Command 00001 enters frame-writing mode so frame data is stored.
// (RULE11) Frame data header may carry zero count; long header gives length.
// (RULE12) Long header 502BA520 takes exactly 2860320 data words.
// (RULE13) First word after long header is first data word, then in order.
// (RULE14) Check register write is compared with computed value; mismatch flags error.
// (RULE15) Command 01010 pulses the global state restore output.
// (RULE16) Command 00011 releases the active-low global hold; also last frame.
// (RULE17) Command 00101 launches the startup sequence.
// (RULE18) Command 01101 clears word alignment; a new sync word is needed.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
module cps_sequencer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cfg_word_valid,
  input wire logic [31:0] cfg_word,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic frame_data_valid,
  output logic [31:0] frame_data,
  output logic [31:0] frame_address_reg,
  output logic [31:0] control_word_zero,
  output logic [31:0] control_word_one,
  output logic global_state_restore,
  output logic global_high_hold_n,
  output logic startup_pulse,
  output logic word_aligned_flag,
  output logic check_error
);
  import cps_pkg::*;
  localparam logic [3:0] CPS_OFS_STATUS = 4'h0;
  localparam logic [3:0] CPS_OFS_EVENTS = 4'h4;
  localparam logic [3:0] CPS_OFS_MASK = 4'h8;
  localparam logic [3:0] CPS_OFS_FRAMES = 4'hc;
  localparam int CPS_EV_N = 4;

  cps_state_e state, next_state;
  logic [4:0] cur_addr, next_cur_addr;
  logic [26:0] count, next_count;
  logic [31:0] mask_word, next_mask_word;
  logic [31:0] next_frame_address_reg, next_control_word_zero, next_control_word_one;
  logic next_write_mode, write_mode;
  logic next_hold_n, next_restore, next_startup, next_error, next_fd_valid;
  logic [31:0] next_frame_data;
  logic [31:0] frame_count, next_frame_count;
  logic [CPS_EV_N-1:0] ev_status, next_ev_status, ev_mask, next_ev_mask, events;
  logic [31:0] next_reg_rdata;
  logic chk_clear, chk_update;
  logic [31:0] chk_value;
  logic [2:0] hdr_type;
  logic [1:0] hdr_op;

  function automatic logic [31:0] cps_masked(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    return (old & ~m) | (nw & m);
  endfunction : cps_masked

  assign hdr_type = cfg_word[CPS_HDR_TYPE_HI:CPS_HDR_TYPE_LO];
  assign hdr_op = cfg_word[CPS_OP_HI:CPS_OP_LO];
  assign word_aligned_flag = (state != CPS_ST_HUNT);

  cps_check_calc u_check (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(chk_clear),
    .update(chk_update),
    .addr(cur_addr),
    .data(cfg_word),
    .value(chk_value)
  );

  always_comb begin
    next_state = state;
    next_cur_addr = cur_addr;
    next_count = count;
    next_mask_word = mask_word;
    next_frame_address_reg = frame_address_reg;
    next_control_word_zero = control_word_zero;
    next_control_word_one = control_word_one;
    next_write_mode = write_mode;
    next_hold_n = global_high_hold_n;
    next_restore = 1'b0;
    next_startup = 1'b0;
    next_error = check_error;
    next_fd_valid = 1'b0;
    next_frame_data = frame_data;
    next_frame_count = frame_count;
    chk_clear = 1'b0;
    chk_update = 1'b0;
    events = '0;
    if (cfg_word_valid) begin
      unique case (state)
        CPS_ST_HUNT: begin
          if (cfg_word == CPS_SYNC_WORD) begin // RULE1
            next_state = CPS_ST_HEADER;
            events[0] = 1'b1;
          end
        end
        CPS_ST_HEADER: begin
          if (hdr_type == CPS_HDR_SINGLE && hdr_op == CPS_OP_WRITE) begin // RULE2
            next_cur_addr = cfg_word[CPS_ADDR_HI:CPS_ADDR_LO];
            next_count = {16'h0000, cfg_word[CPS_WC1_HI:0]};
            if (cfg_word[CPS_WC1_HI:0] != 11'h000) begin // RULE11
              next_state = CPS_ST_DATA;
            end
          end else if (hdr_type == CPS_HDR_LONG && hdr_op == CPS_OP_WRITE) begin // RULE3
            next_count = cfg_word[CPS_WC2_HI:0]; // RULE12
            if (cfg_word[CPS_WC2_HI:0] != CPS_WC_ZERO) begin
              next_state = CPS_ST_DATA;
            end
          end
          // No-op headers, reads and unknown types leave all state unchanged. RULE4
        end
        CPS_ST_DATA: begin
          chk_update = (cur_addr != CPS_REG_CHECK);
          next_count = count - CPS_WC_ONE; // RULE13
          if (count == CPS_WC_ONE) begin
            next_state = CPS_ST_HEADER;
          end
          unique case (cur_addr)
            CPS_REG_CTRL0: next_control_word_zero = cps_masked(control_word_zero, cfg_word, mask_word); // RULE5 RULE7
            CPS_REG_CTRL1: next_control_word_one = cps_masked(control_word_one, cfg_word, mask_word); // RULE5 RULE7
            CPS_REG_MASK: next_mask_word = cfg_word; // RULE6
            CPS_REG_FRAME_ADDR: next_frame_address_reg = cfg_word; // RULE8
            CPS_REG_FRAME_DATA: begin
              if (write_mode) begin // RULE10
                next_fd_valid = 1'b1;
                next_frame_data = cfg_word;
                next_frame_count = frame_count + 32'h00000001;
              end
            end
            CPS_REG_CHECK: begin
              if (cfg_word != chk_value) begin // RULE14
                next_error = 1'b1;
                events[1] = 1'b1;
              end else begin
                next_error = 1'b0;
              end
              chk_clear = 1'b1;
            end
            CPS_REG_COMMAND: begin
              unique case (cfg_word[CPS_CMD_HI:0]) // RULE9
                CPS_CMD_WRITE_FRAMES: next_write_mode = 1'b1; // RULE10
                CPS_CMD_RELEASE_HOLD: begin
                  next_hold_n = 1'b1; // RULE16
                  next_write_mode = 1'b0;
                end
                CPS_CMD_START: begin
                  next_startup = 1'b1; // RULE17
                  events[2] = 1'b1;
                end
                CPS_CMD_RESET_CHECK: chk_clear = 1'b1;
                CPS_CMD_RESTORE: next_restore = 1'b1; // RULE15
                CPS_CMD_DROP_ALIGN: begin
                  next_state = CPS_ST_HUNT; // RULE18
                  next_write_mode = 1'b0;
                  next_count = CPS_WC_ZERO;
                  events[3] = 1'b1;
                end
                default: ;
              endcase
            end
            default: ;
          endcase
        end
        default: next_state = CPS_ST_HUNT;
      endcase
    end
  end

  always_comb begin
    next_ev_mask = ev_mask;
    next_ev_status = ev_status;
    if (reg_wr && reg_addr == CPS_OFS_EVENTS) begin
      next_ev_status = ev_status & ~reg_wdata[CPS_EV_N-1:0];
    end
    next_ev_status = next_ev_status | events;
    if (reg_wr && reg_addr == CPS_OFS_MASK) begin
      next_ev_mask = reg_wdata[CPS_EV_N-1:0];
    end
    next_reg_rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        CPS_OFS_STATUS: next_reg_rdata = {26'h0, write_mode, startup_pulse, global_high_hold_n,
                                          check_error, word_aligned_flag, 1'b0};
        CPS_OFS_EVENTS: next_reg_rdata = {28'h0, ev_status};
        CPS_OFS_MASK: next_reg_rdata = {28'h0, ev_mask};
        CPS_OFS_FRAMES: next_reg_rdata = frame_count;
        default: next_reg_rdata = 32'h00000000;
      endcase
    end
  end

  assign irq = |(ev_status & ev_mask);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= CPS_ST_HUNT;
      cur_addr <= CPS_REG_CHECK;
      count <= CPS_WC_ZERO;
      mask_word <= 32'h00000000;
      frame_address_reg <= 32'h00000000;
      control_word_zero <= 32'h00000000;
      control_word_one <= 32'h00000000;
      write_mode <= 1'b0;
      global_high_hold_n <= 1'b0;
      global_state_restore <= 1'b0;
      startup_pulse <= 1'b0;
      check_error <= 1'b0;
      frame_data_valid <= 1'b0;
      frame_data <= 32'h00000000;
      frame_count <= 32'h00000000;
      ev_status <= '0;
      ev_mask <= '0;
      reg_rdata <= 32'h00000000;
    end else begin
      state <= next_state;
      cur_addr <= next_cur_addr;
      count <= next_count;
      mask_word <= next_mask_word;
      frame_address_reg <= next_frame_address_reg;
      control_word_zero <= next_control_word_zero;
      control_word_one <= next_control_word_one;
      write_mode <= next_write_mode;
      global_high_hold_n <= next_hold_n;
      global_state_restore <= next_restore;
      startup_pulse <= next_startup;
      check_error <= next_error;
      frame_data_valid <= next_fd_valid;
      frame_data <= next_frame_data;
      frame_count <= next_frame_count;
      ev_status <= next_ev_status;
      ev_mask <= next_ev_mask;
      reg_rdata <= next_reg_rdata;
    end
  end

  a_hunt_discards: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
    (state == CPS_ST_HUNT && cfg_word_valid && cfg_word != CPS_SYNC_WORD) |=> state == CPS_ST_HUNT)
    else $error("word accepted before sync");
  a_sync_aligns: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
    (state == CPS_ST_HUNT && cfg_word_valid && cfg_word == CPS_SYNC_WORD) |=> word_aligned_flag)
    else $error("sync word not recognised");
  a_noop_stays: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
    (state == CPS_ST_HEADER && cfg_word_valid && cfg_word == CPS_NOOP_WORD) |=>
    state == CPS_ST_HEADER && $stable(control_word_zero) && $stable(mask_word) && !global_state_restore)
    else $error("noop changed state");
  a_ctrl_masked: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
    ((control_word_zero ^ $past(control_word_zero)) & ~$past(mask_word)) == 32'h00000000)
    else $error("unmasked control bit changed");
  a_mask_load: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
    (state == CPS_ST_DATA && cfg_word_valid && cur_addr == CPS_REG_MASK) |=> mask_word == $past(cfg_word))
    else $error("mask not loaded");
  a_far_load: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
    (state == CPS_ST_DATA && cfg_word_valid && cur_addr == CPS_REG_FRAME_ADDR) |=>
    frame_address_reg == $past(cfg_word))
    else $error("frame address not loaded");
  a_frame_store: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
    frame_data_valid |-> $past(write_mode) && $past(cur_addr) == CPS_REG_FRAME_DATA && frame_data == $past(cfg_word))
    else $error("frame data stored wrongly");
  a_write_mode: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
    (state == CPS_ST_DATA && cfg_word_valid && cur_addr == CPS_REG_COMMAND &&
     cfg_word[CPS_CMD_HI:0] == CPS_CMD_WRITE_FRAMES) |=> write_mode)
    else $error("write mode not entered");
  a_check_flag: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
    (state == CPS_ST_DATA && cfg_word_valid && cur_addr == CPS_REG_CHECK) |=>
    check_error == ($past(cfg_word) != $past(chk_value)))
    else $error("check flag wrong");
  a_restore_pulse: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
    global_state_restore |=> !global_state_restore)
    else $error("restore not a pulse");
  a_restore_cmd: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
    (state == CPS_ST_DATA && cfg_word_valid && cur_addr == CPS_REG_COMMAND &&
     cfg_word[CPS_CMD_HI:0] == CPS_CMD_RESTORE) |=> global_state_restore)
    else $error("restore not pulsed");
  a_hold_release: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
    $rose(global_high_hold_n) |-> $past(cur_addr) == CPS_REG_COMMAND &&
    $past(cfg_word[CPS_CMD_HI:0]) == CPS_CMD_RELEASE_HOLD)
    else $error("hold released without command");
  a_start_cmd: assert property (@(posedge clk_sys) disable iff (rst) // RULE17
    (state == CPS_ST_DATA && cfg_word_valid && cur_addr == CPS_REG_COMMAND &&
     cfg_word[CPS_CMD_HI:0] == CPS_CMD_START) |=> startup_pulse)
    else $error("startup not launched");
  a_long_count: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
    (state == CPS_ST_HEADER && cfg_word_valid && hdr_type == CPS_HDR_LONG && hdr_op == CPS_OP_WRITE &&
     cfg_word[CPS_WC2_HI:0] != CPS_WC_ZERO) |=> state == CPS_ST_DATA && count == $past(cfg_word[CPS_WC2_HI:0]))
    else $error("long count not loaded");
  a_desync: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
    (state == CPS_ST_DATA && cfg_word_valid && cur_addr == CPS_REG_COMMAND &&
     cfg_word[CPS_CMD_HI:0] == CPS_CMD_DROP_ALIGN) |=> !word_aligned_flag)
    else $error("alignment not dropped");
  c_sync: cover property (@(posedge clk_sys) disable iff (rst) $rose(word_aligned_flag));
  c_desync: cover property (@(posedge clk_sys) disable iff (rst) $fell(word_aligned_flag));
  c_frame: cover property (@(posedge clk_sys) disable iff (rst) frame_data_valid);
  c_error: cover property (@(posedge clk_sys) disable iff (rst) $rose(check_error));
  c_start: cover property (@(posedge clk_sys) disable iff (rst) startup_pulse);
endmodule : cps_sequencer

/* tb/cps_host_model.sv */
// Host model that feeds configuration words into the sequencer stream input.
// Assumes its tasks are called just after a rising edge of clk_sys.
`timescale 1ns/1ps
module cps_host_model (
  input wire logic clk_sys,
  output logic cfg_word_valid,
  output logic [31:0] cfg_word
);
  import cps_pkg::*;
  logic [31:0] sent[$];
  initial begin
    cfg_word_valid = 1'b0;
    cfg_word = 32'h0;
  end
  // Released word lines are inverted so stale data never looks held.
  task automatic idle(input int n);
    cfg_word_valid <= 1'b0;
    cfg_word <= ~cfg_word;
    repeat (n) @(posedge clk_sys);
  endtask : idle
  // Sends one word, at random back to back or followed by a pause.
  task automatic send(input logic [31:0] w);
    int gap;
    gap = $urandom_range(0, 2);
    cfg_word_valid <= 1'b1;
    cfg_word <= w;
    @(posedge clk_sys);
    if (gap != 0) idle(gap);
  endtask : send
  task automatic noop(input int n);
    repeat (n) send(CPS_NOOP_WORD);
  endtask : noop
  task automatic wr(input logic [31:0] hdr, input logic [31:0] d);
    send(hdr);
    send(d);
  endtask : wr
  // Frame data write: zero-count single header, then a long header with the length.
  task automatic frames(input int n);
    logic [31:0] w;
    send(32'h30004000);
    send({CPS_HDR_LONG, CPS_OP_WRITE, 27'(n)});
    repeat (n) begin
      w = $urandom;
      sent.push_back(w);
      send(w);
    end
  endtask : frames
endmodule : cps_host_model

/* tb/cps_sequencer_bench.sv */
// Self-checking bench for the configuration packet sequencer.
// Assumes the host model drives the word stream and this module drives the register port.
`timescale 1ns/1ps
module cps_sequencer_bench;
  import cps_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cfg_word_valid;
  logic [31:0] cfg_word;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, frame_data, frame_address_reg, control_word_zero, control_word_one;
  logic irq, frame_data_valid, global_state_restore, global_high_hold_n, startup_pulse;
  logic word_aligned_flag, check_error;
  logic [31:0] got[$];
  logic [31:0] mask, c0, c1, v;
  int n_fail = 0;
  int compares = 0;
  int n_restore = 0;
  int n_start = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  cps_host_model u_host (.clk_sys(clk_sys), .cfg_word_valid(cfg_word_valid), .cfg_word(cfg_word));
  cps_sequencer u_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .cfg_word_valid(cfg_word_valid),
    .cfg_word(cfg_word),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq(irq),
    .frame_data_valid(frame_data_valid),
    .frame_data(frame_data),
    .frame_address_reg(frame_address_reg),
    .control_word_zero(control_word_zero),
    .control_word_one(control_word_one),
    .global_state_restore(global_state_restore),
    .global_high_hold_n(global_high_hold_n),
    .startup_pulse(startup_pulse),
    .word_aligned_flag(word_aligned_flag),
    .check_error(check_error)
  );
  always @(posedge clk_sys) begin
    if (frame_data_valid === 1'b1) got.push_back(frame_data);
    if (global_state_restore === 1'b1) n_restore++;
    if (startup_pulse === 1'b1) n_start++;
  end
  function automatic logic [31:0] masked(input logic [31:0] o, input logic [31:0] d, input logic [31:0] m);
    return (o & ~m) | (d & m);
  endfunction : masked
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
    compares++;
    if (act !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, act);
    end
  endtask : chk
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : reg_write
  task automatic chk_reg(input string name, input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk_sys);
    chk(name, exp, v);
  endtask : chk_reg
  task automatic cmd(input logic [4:0] code);
    v = $urandom;
    v[4:0] = code;
    u_host.wr(32'h30008001, v);
    u_host.idle(3);
  endtask : cmd
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // The tests need a few hundred cycles at most; this limit leaves wide margin.
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h2a0f78d8));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("hold_n", 32'h0, global_high_hold_n);
    chk_reg("status", 4'h0, 32'h0);
    u_host.wr(32'h3000c001, 32'hffffffff);
    u_host.wr(32'h3000a001, 32'hffffffff);
    u_host.idle(3);
    chk("ctrl0 before sync", 32'h0, control_word_zero);
    chk("aligned", 32'h0, word_aligned_flag);
    u_host.send(CPS_SYNC_WORD);
    u_host.noop(3);
    u_host.idle(3);
    chk("aligned", 32'h1, word_aligned_flag);
    chk_reg("events", 4'h4, 32'h1);
    chk("irq masked", 32'h0, irq);
    reg_write(4'h8, 32'h1);
    chk("irq", 32'h1, irq);
    reg_write(4'h4, 32'h1);
    chk("irq cleared", 32'h0, irq);
    chk_reg("events", 4'h4, 32'h0);
    chk_reg("unmapped", 4'h6, 32'h0);
    reg_write(4'h8, 32'hf);
    $display("test align done");
    c0 = 32'h0;
    c1 = 32'h0;
    for (int i = 0; i < 6; i++) begin
      mask = (i == 0) ? 32'hffffffff : $urandom;
      u_host.wr(32'h3000c001, mask);
      v = $urandom;
      u_host.wr(32'h3000a001, v);
      c0 = masked(c0, v, mask);
      v = $urandom;
      u_host.wr(32'h30030001, v);
      c1 = masked(c1, v, mask);
      u_host.noop(2);
      u_host.idle(3);
      chk("control_word_zero", c0, control_word_zero);
      chk("control_word_one", c1, control_word_one);
    end
    $display("test control done");
    u_host.wr(32'h30000001, $urandom | 32'h1);
    u_host.idle(3);
    chk("check_error", 32'h1, check_error);
    cmd(CPS_CMD_RESET_CHECK);
    u_host.wr(32'h30000001, 32'h0);
    u_host.idle(3);
    chk("check_error", 32'h0, check_error);
    $display("test check done");
    u_host.frames(2);
    u_host.idle(3);
    chk("frames without write mode", 32'h0, got.size());
    u_host.sent.delete();
    cmd(CPS_CMD_WRITE_FRAMES);
    chk_reg("status", 4'h0, 32'h22);
    n = $urandom_range(3, 9);
    u_host.frames(n);
    v = $urandom;
    u_host.wr(32'h30002001, v);
    u_host.idle(3);
    chk("frame_address_reg", v, frame_address_reg);
    chk("frame count", n, got.size());
    for (int i = 0; i < n && i < got.size(); i++) chk("frame word", u_host.sent[i], got[i]);
    chk_reg("frames stored", 4'hc, n);
    $display("test frames done");
    cmd(CPS_CMD_RESTORE);
    chk("restore pulses", 32'h1, n_restore);
    cmd(CPS_CMD_RELEASE_HOLD);
    chk("hold_n", 32'h1, global_high_hold_n);
    cmd(CPS_CMD_START);
    chk("startup pulses", 32'h1, n_start);
    $display("test commands done");
    cmd(CPS_CMD_DROP_ALIGN);
    chk("aligned", 32'h0, word_aligned_flag);
    u_host.wr(32'h3000c001, 32'hffffffff);
    u_host.wr(32'h3000a001, ~c0);
    u_host.send(CPS_SYNC_WORD);
    u_host.idle(3);
    chk("ctrl0 after desync", c0, control_word_zero);
    chk("aligned", 32'h1, word_aligned_flag);
    chk_reg("events", 4'h4, 32'hf);
    chk("irq", 32'h1, irq);
    chk_reg("status", 4'h0, 32'h0a);
    $display("test desync done");
    tally_and_finish;
  end
endmodule : cps_sequencer_bench
